/* File: core/cdc_consts.vh */
// Constants for the machine-cycle sequencer.
// Included by the sequencer and its timing generator.
`ifndef CDC_CONSTS_VH
`define CDC_CONSTS_VH
// Machine states
`define CDC_ST_FETCH 2'h0
`define CDC_ST_EXEC 2'h1
`define CDC_ST_DMA 2'h2
`define CDC_ST_INT 2'h3
// Clocks per machine cycle and timing pulse slot
`define CDC_CYCLE_LEN 3'h4
`define CDC_TPA_SLOT 3'h1
`define CDC_WR_SLOT 3'h2
`define CDC_TPB_SLOT 3'h3
// Opcode groups
`define CDC_OP_IO 4'h6
`define CDC_OP_IDLE 8'h00
`define CDC_OP_RET 8'h70
`define CDC_OP_DIS 8'h71
`define CDC_OP_OUT_LO 4'h1
`define CDC_OP_OUT_HI 4'h7
`define CDC_OP_IN_LO 4'h9
// Interrupt vector selectors
`define CDC_INT_X 4'h2
`define CDC_INT_P 4'h1
// Reset values
`define CDC_IE_RESET 1'b1
`define CDC_PTR_RESET 16'h0000
`endif

/* File: core/cdc_cycle_timer.v */
// Counts the clocks inside one machine cycle and marks its slots.
// Assumes one clock; no clock enable, synchronous active-low reset.
`timescale 1ns/100ps
`include "cdc_consts.vh"
module cdc_cycle_timer #(
    parameter CW = 3
) (
    input wire clk,
    input wire rstn,
    output reg [CW-1:0] slot_q,
    output wire lastSlot
);
    wire [CW-1:0] lastVal;
    assign lastVal = `CDC_CYCLE_LEN - 3'h1;
    assign lastSlot = (slot_q == lastVal);
    // Free-running slot counter, wraps at end of cycle
    always @(posedge clk) begin
        if (!rstn) begin
            slot_q <= {CW{1'b0}};
        end else if (lastSlot) begin
            slot_q <= {CW{1'b0}};
        end else begin
            slot_q <= slot_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* File: core/cdc_io_seq.v */
// Machine-cycle sequencer for fetch, I/O execute, DMA and interrupt entry.
// Assumes external memory and I/O on a shared bus, one clock domain.
// Function
// [RULE1] Fetch asserts read strobe and loads opcode high and low fields.
// [RULE2] Input execute is a write cycle with a low write pulse.
// [RULE3] Input byte goes to memory at I/O pointer and accumulator.
// [RULE4] Read strobe stays high through an input execute cycle.
// [RULE5] Opcode 69-6F presents low three bits for input device select.
// [RULE6] Output execute reads memory at I/O pointer, then increments it.
// [RULE7] Opcode 61-67 presents low three bits during output execute.
// [RULE8] Output device latches on timing pulse, select and read strobe.
// [RULE9] DMA waits until the current instruction cycle completes.
// [RULE10] DMA requests sampled at timing pulse ending execute, DMA, irq.
// [RULE11] DMA write is a write cycle at DMA pointer, read strobe high.
// [RULE12] DMA pointer increments after each DMA input transfer.
// [RULE13] DMA read is a read cycle at DMA pointer, then increments.
// [RULE14] DMA output receiver strobes during DMA state on timing pulse.
// [RULE15] Request withdrawn in DMA state leads to fetch next.
// [RULE16] Interrupt sampled at end of execute, taken only if enabled.
// [RULE17] Interrupt state saves selectors, loads 2 and 1.
// [RULE18] Entering interrupt state clears interrupt enable.
// [RULE19] Cycle after interrupt state is a fetch with new counter; the code enters DMA instead when a DMA request is pending.
// [RULE20] DMA beats interrupt when both pending.
// [RULE21] Reset sets interrupt enable; return sets, disable clears it.
`timescale 1ns/100ps
`include "cdc_consts.vh"
module cdc_io_seq #(
    parameter AW = 16,
    parameter DW = 8
) (
    input wire clk,
    input wire rstn,
    input wire [DW-1:0] dataIn,
    input wire dmaWriteRequestN,
    input wire dmaReadRequestN,
    input wire interruptRequestN,
    input wire [AW-1:0] ioPointerIn,
    input wire [AW-1:0] fetchAddrIn,
    output reg [AW-1:0] address_q,
    output reg [DW-1:0] dataOut_q,
    output reg dataOutEn_q,
    output reg memoryReadStrobeN_q,
    output reg memoryWriteStrobeN_q,
    output reg timingPulseA_q,
    output reg timingPulseB_q,
    output reg [2:0] ioSelect_q,
    output reg [1:0] state_q,
    output reg [3:0] upperOpCode_q,
    output reg [3:0] lowOpcodeField_q,
    output reg [DW-1:0] accumulator_q,
    output reg [AW-1:0] ioMemoryPointer_q,
    output reg [AW-1:0] dmaPointer_q,
    output reg [3:0] dataPointerSelect_q,
    output reg [3:0] counterSelector_q,
    output reg [7:0] savedXpReg_q,
    output reg interruptEnableFlag_q,
    output reg ioPointerIncr_q
);
    wire [2:0] slot;
    wire lastSlot;
    reg [1:0] state_d;
    reg dmaWrSampled_q;
    reg dmaRdSampled_q;
    reg irqSampled_q;
    wire isIoOp;
    wire isOutOp;
    wire isInOp;
    wire [7:0] opcode;
    wire [AW-1:0] one;
    // Decode of the coming cycle and cycle-class helpers
    wire [7:0] opNext;
    wire nextIsIo;
    wire nextIsOut;
    wire nextIsIn;
    wire fetchEnd;
    wire sampleEdge;
    wire writeEdge;
    wire dmaPending;
    wire irqTaken;
    wire dmaWriteCycle;
    reg dmaIsWrite_q;
    reg cycRead;
    reg cycWrite;
    reg [AW-1:0] address_d;
    reg [2:0] ioSelect_d;

    cdc_cycle_timer #(
        .CW(3)
    ) uTimer (
        .clk(clk),
        .rstn(rstn),
        .slot_q(slot),
        .lastSlot(lastSlot)
    );

    assign one = {{(AW-1){1'b0}}, 1'b1};
    assign opcode = {upperOpCode_q, lowOpcodeField_q};
    assign isIoOp = (upperOpCode_q == `CDC_OP_IO);
    // Output 61-67, input 69-6F
    assign isOutOp = isIoOp && (lowOpcodeField_q >= `CDC_OP_OUT_LO)
        && (lowOpcodeField_q <= `CDC_OP_OUT_HI);
    assign isInOp = isIoOp && (lowOpcodeField_q >= `CDC_OP_IN_LO);

    // Opcode of the coming cycle; at fetch end it is still on the bus
    assign fetchEnd = (state_q == `CDC_ST_FETCH) && lastSlot;
    assign opNext = fetchEnd ? dataIn[7:0] : opcode;
    assign nextIsIo = (opNext[7:4] == `CDC_OP_IO);
    assign nextIsOut = nextIsIo && (opNext[3:0] >= `CDC_OP_OUT_LO)
        && (opNext[3:0] <= `CDC_OP_OUT_HI);
    assign nextIsIn = nextIsIo && (opNext[3:0] >= `CDC_OP_IN_LO);

    // Slot markers and pending requests
    assign sampleEdge = (slot == `CDC_TPB_SLOT - 3'h1);
    assign writeEdge = (slot == `CDC_WR_SLOT - 3'h1);
    assign dmaPending = dmaWrSampled_q || dmaRdSampled_q;
    assign irqTaken = irqSampled_q && interruptEnableFlag_q;

    // DMA direction, frozen once the DMA cycle has begun
    assign dmaWriteCycle = (state_q == `CDC_ST_DMA) ? dmaIsWrite_q
        : dmaWrSampled_q;

    // DMA requests sampled with timing pulse B
    always @(posedge clk) begin
        if (!rstn) begin
            dmaWrSampled_q <= 1'b0;
            dmaRdSampled_q <= 1'b0;
        end else if (sampleEdge) begin
            dmaWrSampled_q <= !dmaWriteRequestN; // [RULE10]
            dmaRdSampled_q <= !dmaReadRequestN; // [RULE10]
        end
    end

    // Interrupt request sampled at the same point
    always @(posedge clk) begin
        if (!rstn) begin
            irqSampled_q <= 1'b0;
        end else if (sampleEdge) begin
            irqSampled_q <= !interruptRequestN; // [RULE16]
        end
    end

    // Next machine state chosen at end of cycle
    always @* begin
        state_d = state_q;
        if (lastSlot) begin
            case (state_q)
                `CDC_ST_FETCH: begin
                    // [RULE9] fetch always runs into its execute
                    state_d = `CDC_ST_EXEC;
                end
                `CDC_ST_EXEC, `CDC_ST_DMA, `CDC_ST_INT: begin
                    if (dmaPending) begin
                        state_d = `CDC_ST_DMA; // [RULE20] [RULE9]
                    end else if (state_q == `CDC_ST_EXEC && irqTaken) begin
                        state_d = `CDC_ST_INT; // [RULE16]
                    end else if (state_q == `CDC_ST_EXEC
                        && opcode == `CDC_OP_IDLE) begin
                        state_d = `CDC_ST_EXEC;
                    end else begin
                        state_d = `CDC_ST_FETCH; // [RULE15] [RULE19]
                    end
                end
                default: begin
                    state_d = `CDC_ST_FETCH;
                end
            endcase
        end
    end

    // State register
    always @(posedge clk) begin
        if (!rstn) begin
            state_q <= `CDC_ST_FETCH;
        end else begin
            state_q <= state_d;
        end
    end

    // Timing pulse A, one clock in slot 1
    always @(posedge clk) begin
        if (!rstn) begin
            timingPulseA_q <= 1'b0;
        end else begin
            timingPulseA_q <= (slot == `CDC_TPA_SLOT - 3'h1);
        end
    end

    // Timing pulse B, one clock in slot 3, launched with request sampling
    always @(posedge clk) begin
        if (!rstn) begin
            timingPulseB_q <= 1'b0;
        end else begin
            timingPulseB_q <= sampleEdge; // [RULE10]
        end
    end

    // Memory cycle class, address and selects of the coming cycle
    always @* begin
        cycRead = 1'b0;
        cycWrite = 1'b0;
        address_d = address_q;
        ioSelect_d = 3'h0;
        case (state_d)
            `CDC_ST_FETCH: begin
                cycRead = 1'b1; // [RULE1]
                address_d = fetchAddrIn;
            end
            `CDC_ST_EXEC: begin
                address_d = ioMemoryPointer_q;
                if (nextIsIn) begin
                    // Memory kept off the bus from the first clock
                    cycWrite = 1'b1; // [RULE2] [RULE4]
                    ioSelect_d = opNext[2:0]; // [RULE5]
                end else if (nextIsOut) begin
                    cycRead = 1'b1; // [RULE6]
                    ioSelect_d = opNext[2:0]; // [RULE7] [RULE8]
                end else begin
                    cycRead = 1'b1;
                end
            end
            `CDC_ST_DMA: begin
                address_d = dmaPointer_q;
                if (dmaWriteCycle) begin
                    cycWrite = 1'b1; // [RULE11]
                end else begin
                    cycRead = 1'b1; // [RULE13] [RULE14]
                end
            end
            `CDC_ST_INT: begin
                // Non-memory cycle: both strobes stay high
                cycRead = 1'b0;
            end
            default: begin
                cycRead = 1'b0;
            end
        endcase
    end

    // Strobes, address and I/O selects registered for the pins
    always @(posedge clk) begin
        if (!rstn) begin
            memoryReadStrobeN_q <= 1'b1;
            memoryWriteStrobeN_q <= 1'b1;
            address_q <= `CDC_PTR_RESET;
            ioSelect_q <= 3'h0;
            dataOut_q <= {DW{1'b0}};
            dataOutEn_q <= 1'b0;
        end else begin
            memoryReadStrobeN_q <= !cycRead; // [RULE4]
            // Write pulse lands in slot 2 of a write cycle
            memoryWriteStrobeN_q <= !(cycWrite && writeEdge); // [RULE2]
            address_q <= address_d;
            ioSelect_q <= ioSelect_d;
            dataOut_q <= {DW{1'b0}};
            dataOutEn_q <= 1'b0;
        end
    end

    // Opcode fields loaded at the end of fetch
    always @(posedge clk) begin
        if (!rstn) begin
            upperOpCode_q <= 4'h0;
            lowOpcodeField_q <= 4'h0;
        end else if (fetchEnd) begin
            upperOpCode_q <= dataIn[7:4]; // [RULE1]
            lowOpcodeField_q <= dataIn[3:0]; // [RULE1]
        end
    end

    // Accumulator takes the input byte at the end of an input execute
    always @(posedge clk) begin
        if (!rstn) begin
            accumulator_q <= {DW{1'b0}};
        end else if (state_q == `CDC_ST_EXEC && lastSlot && isInOp) begin
            accumulator_q <= dataIn; // [RULE3]
        end
    end

    // I/O pointer: loaded during fetch, advanced after an output byte
    always @(posedge clk) begin
        if (!rstn) begin
            ioMemoryPointer_q <= `CDC_PTR_RESET;
        end else if (state_q == `CDC_ST_FETCH && sampleEdge) begin
            // Loaded before fetch ends so the execute address is ready
            ioMemoryPointer_q <= ioPointerIn;
        end else if (state_q == `CDC_ST_EXEC && lastSlot && isOutOp) begin
            ioMemoryPointer_q <= ioMemoryPointer_q + one; // [RULE6]
        end
    end

    // Pulse marking each I/O pointer advance
    always @(posedge clk) begin
        if (!rstn) begin
            ioPointerIncr_q <= 1'b0;
        end else begin
            ioPointerIncr_q <= (state_q == `CDC_ST_EXEC) && lastSlot
                && isOutOp; // [RULE6]
        end
    end

    // DMA pointer advances after every DMA byte, both directions
    always @(posedge clk) begin
        if (!rstn) begin
            dmaPointer_q <= `CDC_PTR_RESET;
        end else if (state_q == `CDC_ST_DMA && lastSlot) begin
            dmaPointer_q <= dmaPointer_q + one; // [RULE12] [RULE13]
        end
    end

    // Direction of a DMA cycle, held so a late withdrawal cannot flip it
    always @(posedge clk) begin
        if (!rstn) begin
            dmaIsWrite_q <= 1'b0;
        end else if (lastSlot) begin
            dmaIsWrite_q <= dmaWrSampled_q; // [RULE11]
        end
    end

    // Selector save on interrupt entry
    always @(posedge clk) begin
        if (!rstn) begin
            dataPointerSelect_q <= 4'h0;
            counterSelector_q <= 4'h0;
            savedXpReg_q <= 8'h00;
        end else if (lastSlot && state_d == `CDC_ST_INT) begin
            savedXpReg_q <= {dataPointerSelect_q,
                counterSelector_q}; // [RULE17]
            dataPointerSelect_q <= `CDC_INT_X; // [RULE17]
            counterSelector_q <= `CDC_INT_P; // [RULE17] [RULE19]
        end
    end

    // Interrupt enable: set by reset and return, cleared on entry
    always @(posedge clk) begin
        if (!rstn) begin
            interruptEnableFlag_q <= `CDC_IE_RESET; // [RULE21]
        end else if (lastSlot && state_d == `CDC_ST_INT) begin
            interruptEnableFlag_q <= 1'b0; // [RULE18]
        end else if (lastSlot && state_q == `CDC_ST_EXEC
            && opcode == `CDC_OP_RET) begin
            interruptEnableFlag_q <= 1'b1; // [RULE21]
        end else if (lastSlot && state_q == `CDC_ST_EXEC
            && opcode == `CDC_OP_DIS) begin
            interruptEnableFlag_q <= 1'b0; // [RULE21]
        end
    end
endmodule

/* File: tb/cdc_io_seq_assertions.sv */
// Checker for the sequencer's strobes, states and selects.
// Bound to cdc_io_seq; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module cdc_io_seq_assertions (
    input wire clk,
    input wire rstn,
    input wire dmaWriteRequestN,
    input wire memoryReadStrobeN_q,
    input wire memoryWriteStrobeN_q,
    input wire timingPulseA_q,
    input wire timingPulseB_q,
    input wire [2:0] ioSelect_q,
    input wire [1:0] state_q,
    input wire [3:0] upperOpCode_q,
    input wire [3:0] lowOpcodeField_q,
    input wire interruptEnableFlag_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // I/O execute decode and short names
    wire ioEx = state_q == 2'h1 && upperOpCode_q == 4'h6
        && lowOpcodeField_q[2:0] != 3'h0;
    wire inEx = ioEx && lowOpcodeField_q[3];
    wire outEx = ioEx && !lowOpcodeField_q[3];
    wire rdN = memoryReadStrobeN_q;
    wire wrN = memoryWriteStrobeN_q;
    wire tpa = timingPulseA_q;
    wire timing_pulse_b = timingPulseB_q;
    wire ie = interruptEnableFlag_q;
    wire [1:0] st = state_q;
    a_fetch_read: assert property (
        st == 2'h0 && tpa |-> !rdN) else $error("fetch without read");
    a_input_write: assert property (
        inEx && tpa |-> rdN ##1 (!wrN && rdN)) else $error("bad input");
    a_input_quiet: assert property (
        inEx |-> rdN) else $error("read strobe low in input");
    a_io_select: assert property (
        ioEx && tpa |-> ioSelect_q == lowOpcodeField_q[2:0])
        else $error("select bits wrong");
    a_output_read: assert property (
        outEx && tpa |-> !rdN ##1 wrN) else $error("bad output");
    a_dma_write: assert property (
        st == 2'h2 && rdN && tpa |-> ##1 !wrN) else $error("no dma write");
    a_dma_first: assert property (
        timing_pulse_b && st != 2'h0 && !$past(dmaWriteRequestN) |-> ##[1:2] st == 2'h2)
        else $error("dma not taken");
    a_int_clears: assert property (
        st == 2'h3 && timing_pulse_b |-> !ie) else $error("enable not cleared");
    a_int_fetch: assert property (
        st == 2'h3 && timing_pulse_b |-> ##[1:2] st == 2'h0) else $error("no fetch");
    a_int_gated: assert property (
        st == 2'h1 && timing_pulse_b && !ie |-> ##1 st != 2'h3 ##1 st != 2'h3)
        else $error("masked irq taken");
    a_int_nomem: assert property (
        st == 2'h3 && tpa |-> rdN && wrN) else $error("irq used memory");
    c_input: cover property (inEx && !wrN);
    c_dma: cover property (st == 2'h2 && timing_pulse_b);
    c_int: cover property (st == 2'h3 && timing_pulse_b);
endmodule
bind cdc_io_seq cdc_io_seq_assertions cdc_io_seq_assertions_i (
    .clk(clk), .rstn(rstn), .dmaWriteRequestN(dmaWriteRequestN),
    .memoryReadStrobeN_q(memoryReadStrobeN_q),
    .memoryWriteStrobeN_q(memoryWriteStrobeN_q),
    .timingPulseA_q(timingPulseA_q), .timingPulseB_q(timingPulseB_q),
    .ioSelect_q(ioSelect_q), .state_q(state_q),
    .upperOpCode_q(upperOpCode_q), .lowOpcodeField_q(lowOpcodeField_q),
    .interruptEnableFlag_q(interruptEnableFlag_q)
);

/* File: tb/cdc_mem_model.sv */
// Memory plus I/O and DMA devices on the shared data bus.
// Assumes registered strobes from the sequencer, one clock.
`timescale 1ns/100ps
module cdc_mem_model (
    input wire clk,
    input wire [15:0] address,
    input wire readN,
    input wire writeN,
    input wire timing_pulse_b,
    input wire [1:0] state,
    input wire [2:0] ioSel,
    input wire [7:0] devByte,
    output reg [7:0] busOut,
    output reg [7:0] latched
);
    reg [7:0] mem [0:65535];
    reg [7:0] last = 8'h00;
    // Memory, a selected device, or a toggling released bus
    always @* begin
        if (!readN)
            busOut = mem[address];
        else if (state == 2'h2 || ioSel != 3'h0)
            busOut = devByte;
        else
            busOut = ~last;
    end
    // Memory write and device strobes
    always @(posedge clk) begin
        last <= busOut;
        if (!writeN)
            mem[address] <= busOut;
        if (timing_pulse_b && !readN && (ioSel != 3'h0 || state == 2'h2))
            latched <= busOut;
    end
endmodule

/* File: tb/cdc_io_seq_tb_top.sv */
// Self-checking bench for the machine-cycle sequencer.
// Assumes the memory model and bound checker beside the sequencer.
`timescale 1ns/100ps
module cdc_io_seq_tb_top;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg dmaWrN = 1'b1;
    reg dmaRdN = 1'b1;
    reg irqN = 1'b1;
    reg [15:0] ioPtr = 16'h0000;
    reg [7:0] devByte = 8'h00;
    reg [15:0] p;
    reg [7:0] xp;
    wire [7:0] bus, acc, lat, sxp;
    wire [15:0] addr, iop, dmp;
    wire [3:0] up, lo, dps, cs;
    wire [2:0] ioSel;
    wire [1:0] st;
    wire mrdN, mwrN, timing_pulse_b, ie;
    int err_total = 0;
    int samples_checked = 0;
    cdc_io_seq cdc_io_seq_i (
        .clk(clk), .rstn(rstn), .dataIn(bus),
        .dmaWriteRequestN(dmaWrN), .dmaReadRequestN(dmaRdN),
        .interruptRequestN(irqN), .ioPointerIn(ioPtr),
        .fetchAddrIn(16'h0100), .address_q(addr), .dataOut_q(),
        .dataOutEn_q(), .memoryReadStrobeN_q(mrdN),
        .memoryWriteStrobeN_q(mwrN), .timingPulseA_q(),
        .timingPulseB_q(timing_pulse_b), .ioSelect_q(ioSel), .state_q(st),
        .upperOpCode_q(up), .lowOpcodeField_q(lo), .accumulator_q(acc),
        .ioMemoryPointer_q(iop), .dmaPointer_q(dmp),
        .dataPointerSelect_q(dps), .counterSelector_q(cs),
        .savedXpReg_q(sxp), .interruptEnableFlag_q(ie),
        .ioPointerIncr_q()
    );
    cdc_mem_model cdc_mem_model_i (
        .clk(clk), .address(addr), .readN(mrdN), .writeN(mwrN),
        .timing_pulse_b(timing_pulse_b), .state(st), .ioSel(ioSel), .devByte(devByte),
        .busOut(bus), .latched(lat)
    );
    always #50 clk = ~clk;
    task chk(input string nm, input [15:0] exp, input [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // Bounded wait for a machine state
    task wait_st(input [1:0] s);
        int n;
        n = 0;
        @(negedge clk);
        while (st !== s && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("state", s, st);
    endtask
    // Runs one instruction at the fetch address
    task run_op(input [7:0] op);
        cdc_mem_model_i.mem[16'h0100] = op;
        wait_st(2'h1);
        wait_st(2'h0);
        wait_st(2'h1);
        chk("opcode", op, {up, lo});
        wait_st(2'h0);
        cdc_mem_model_i.mem[16'h0100] = 8'h60;
    endtask
    task t_io;
        @(posedge clk);
        ioPtr <= 16'h0040;
        devByte <= 8'ha5;
        run_op(8'h6c);
        chk("acc", 16'h00a5, acc);
        chk("mem", 16'h00a5, cdc_mem_model_i.mem[16'h0040]);
        @(posedge clk);
        ioPtr <= 16'h0050;
        cdc_mem_model_i.mem[16'h0050] = 8'h3c;
        run_op(8'h64);
        chk("latch", 16'h003c, lat);
        chk("iop", 16'h0051, iop);
    endtask
    task t_dma;
        p = dmp;
        @(posedge clk);
        dmaWrN <= 1'b0;
        devByte <= 8'h5a;
        wait_st(2'h2);
        @(posedge clk);
        dmaWrN <= 1'b1;
        wait_st(2'h0);
        chk("dmamem", 16'h005a, cdc_mem_model_i.mem[p]);
        chk("dmp", p + 16'h0001, dmp);
        cdc_mem_model_i.mem[p + 16'h0001] = 8'hc3;
        @(posedge clk);
        dmaRdN <= 1'b0;
        wait_st(2'h2);
        @(posedge clk);
        dmaRdN <= 1'b1;
        wait_st(2'h0);
        chk("latch", 16'h00c3, lat);
        chk("dmp", p + 16'h0002, dmp);
    endtask
    task t_irq;
        @(posedge clk);
        dmaWrN <= 1'b0;
        irqN <= 1'b0;
        wait_st(2'h2);
        chk("enable", 16'h0001, ie);
        xp = {dps, cs};
        @(posedge clk);
        dmaWrN <= 1'b1;
        wait_st(2'h3);
        wait_st(2'h0);
        chk("enable", 16'h0000, ie);
        chk("xp", 16'h0021, {dps, cs});
        chk("saved", xp, sxp);
        run_op(8'h60);
        chk("saved", xp, sxp);
        @(posedge clk);
        irqN <= 1'b1;
        run_op(8'h70);
        chk("enable", 16'h0001, ie);
        run_op(8'h71);
        chk("enable", 16'h0000, ie);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hung run short
    initial begin
        #(4000 * 100);
        err_total++;
        report_and_stop;
    end
    // Reset, then the scenarios
    initial begin
        cdc_mem_model_i.mem[16'h0100] = 8'h60;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("enable", 16'h0001, ie);
        t_io;
        t_dma;
        t_irq;
        report_and_stop;
    end
endmodule
